// ---- dtc_pin_model.sv ----
// dtc_pin_model: far-side source for the count and gate pins.
// assumes the bench calls its tasks from the ref_clk_in domain.
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_model
(
	input wire logic ref_clk_in,
	output logic [1:0] count_pin_out,
	output logic [1:0] gate_pin_out
);
	// count pins idle high, gates closed
	initial
	begin
		count_pin_out = 2'h3;
		gate_pin_out = 2'h0;
	end
	// four clocks low and five high per pulse so every fall survives the synchroniser
	task automatic pulse_edges(input int idx, input int n);
		repeat (n)
		begin
			@(posedge ref_clk_in);
			count_pin_out[idx] <= 1'b0;
			repeat (4) @(posedge ref_clk_in);
			count_pin_out[idx] <= 1'b1;
			repeat (4) @(posedge ref_clk_in);
		end
	endtask
	// gate stays high across the whole measured interval
	task automatic set_gate(input int idx, input logic lvl);
		@(posedge ref_clk_in);
		gate_pin_out[idx] <= lvl;
	endtask
endmodule
`default_nettype wire

// ---- dtc_pkg.sv ----
// dtc_pkg: register map, field positions and reset values of the dual timer/counter.
// assumes a byte-wide register port with offsets matching the classic special-register map.
package dtc_pkg;
	localparam logic [7:0] DTC_ADDR_RUN_FLAG = 8'h88; // timer_run_flag_ctrl
	localparam logic [7:0] DTC_ADDR_MODE = 8'h89; // timer_mode_cfg
	localparam logic [7:0] DTC_ADDR_T0_LOW = 8'h8a;
	localparam logic [7:0] DTC_ADDR_T1_LOW = 8'h8b;
	localparam logic [7:0] DTC_ADDR_T0_HIGH = 8'h8c;
	localparam logic [7:0] DTC_ADDR_T1_HIGH = 8'h8d;
	localparam logic [7:0] DTC_ADDR_IRQ_STAT = 8'h90; // chosen offsets
	localparam logic [7:0] DTC_ADDR_IRQ_MASK = 8'h91;
	// run/flag register bit positions
	localparam int DTC_BIT_T1_FLAG = 7;
	localparam int DTC_BIT_T1_RUN = 6;
	localparam int DTC_BIT_T0_FLAG = 5;
	localparam int DTC_BIT_T0_RUN = 4;
	// mode nibble field positions, per timer nibble
	localparam int DTC_FLD_GATE = 3;
	localparam int DTC_FLD_CT = 2;
	localparam int DTC_T1_NIBBLE = 4;
	localparam logic [7:0] DTC_RST_RUN_FLAG = 8'h00;
	localparam logic [7:0] DTC_RST_MODE = 8'h00;
	localparam logic [7:0] DTC_RST_COUNT = 8'h00;
	localparam logic [1:0] DTC_RST_IRQ = 2'h0;
	localparam logic [3:0] DTC_PRESCALE_LAST = 4'hb; // twelve clocks per tick
	localparam logic [4:0] DTC_MODE0_LOW_MAX = 5'h1f; // divide-by-32 prescaler
	typedef enum logic [1:0] {DTC_MODE_13BIT, DTC_MODE_16BIT, DTC_MODE_RELOAD, DTC_MODE_SPLIT}
		dtc_mode_t;
	typedef struct packed {
		logic gate_sel;
		logic ct_sel;
		dtc_mode_t mode;
	} dtc_nibble_t;
endpackage

// ---- dtc_top.sv ----
// dtc_top: two timer/counters with run/flag, mode and count registers plus an irq block.
// assumes count and gate pins are asynchronous; register port is on ref_clk_in.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - timer mode ticks every twelve clocks
// - counter mode ticks on pin falling edge
// - pins sampled each clock, edge from samples
// - each timer is high and low byte
// - mode 0: high byte after 32 prescaler
// - mode 1: low carries into high, 16 bit
// - mode 2: low byte reloads from high
// - mode 3: split bytes, high uses timer1 controls
// - timer1 in mode 3 holds its count
// - mode register: gate, ct, two mode bits
// - gate set needs gate pin high too
// - ct selects pin events or internal clock
// - run bits at 4 and 6
// - rollover of valid bits sets overflow flag
// - flag cleared on vector ack, software writable
// - reload leaves high byte unchanged
// - mode 0 low upper three bits ignored
module dtc_top
	import dtc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [1:0] vector_ack_in,
	input wire logic timer_zero_count_pin_in,
	input wire logic timer_one_count_pin_in,
	input wire logic timer_zero_gate_pin_in,
	input wire logic timer_one_gate_pin_in,
	output logic [1:0] overflow_flag_out,
	output logic irq_out
);
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic [1:0] cnt_prev_q;
	logic [3:0] prescale_q;
	logic tick12_q;
	logic [7:0] run_flag_q;
	logic [7:0] mode_q;
	logic [7:0] low_q [2];
	logic [7:0] high_q [2];
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [1:0] ovf_set;
	logic [1:0] low_inc;
	logic [1:0] high_inc;
	logic split_high_inc;
	logic split_high_ovf;
	logic wr_run_flag;
	dtc_nibble_t nib [2];
	logic [1:0] pin_fall;
	logic [1:0] ext_gate;

	assign nib[0] = dtc_nibble_t'(mode_q[3:0]);
	assign nib[1] = dtc_nibble_t'(mode_q[7:4]);
	assign wr_run_flag = reg_wr_in && (reg_addr_in == DTC_ADDR_RUN_FLAG);

	// two-stage synchroniser for count and gate pins
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_meta_q <= 4'h0;
			pin_sync_q <= 4'h0;
			cnt_prev_q <= 2'h0;
		end
		else if (clk_en_in)
		begin
			pin_meta_q <= {timer_one_gate_pin_in, timer_zero_gate_pin_in,
				timer_one_count_pin_in, timer_zero_count_pin_in};
			pin_sync_q <= pin_meta_q;
			cnt_prev_q <= pin_sync_q[1:0];
		end
	end
	assign pin_fall = cnt_prev_q & ~pin_sync_q[1:0];
	assign ext_gate = pin_sync_q[3:2];

	// shared divide-by-twelve for timer mode
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prescale_q <= 4'h0;
			tick12_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			tick12_q <= (prescale_q == DTC_PRESCALE_LAST);
			prescale_q <= (prescale_q == DTC_PRESCALE_LAST) ? 4'h0 : prescale_q + 4'h1;
		end
	end

	// per-timer enable and count-event decode
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_en
			logic run_bit;
			logic enabled;
			logic src;
			assign run_bit = run_flag_q[gi == 0 ? DTC_BIT_T0_RUN : DTC_BIT_T1_RUN];
			// gate pin only matters when gate select is set
			assign enabled = run_bit && (!nib[gi].gate_sel || ext_gate[gi]);
			assign src = nib[gi].ct_sel ? pin_fall[gi] : tick12_q;
			// timer one frozen in split mode
			assign low_inc[gi] = enabled && src &&
				!(gi == 1 && nib[1].mode == DTC_MODE_SPLIT);
		end
	endgenerate

	// split-mode high byte: timer only, gated by timer one run bit
	assign split_high_inc = (nib[0].mode == DTC_MODE_SPLIT) && run_flag_q[DTC_BIT_T1_RUN]
		&& tick12_q;
	assign split_high_ovf = split_high_inc && (high_q[0] == 8'hff);

	// counter datapath per timer
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cnt
			logic low_wr;
			logic high_wr;
			logic low_max;
			assign low_wr = reg_wr_in &&
				(reg_addr_in == (gi == 0 ? DTC_ADDR_T0_LOW : DTC_ADDR_T1_LOW));
			assign high_wr = reg_wr_in &&
				(reg_addr_in == (gi == 0 ? DTC_ADDR_T0_HIGH : DTC_ADDR_T1_HIGH));
			// mode 0 looks only at the lower five bits
			assign low_max = (nib[gi].mode == DTC_MODE_13BIT) ?
				(low_q[gi][4:0] == DTC_MODE0_LOW_MAX) : (low_q[gi] == 8'hff);
			always_comb
			begin
				high_inc[gi] = 1'b0;
				ovf_set[gi] = 1'b0;
				case (nib[gi].mode)
					DTC_MODE_13BIT, DTC_MODE_16BIT:
					begin
						high_inc[gi] = low_inc[gi] && low_max;
						ovf_set[gi] = high_inc[gi] && (high_q[gi] == 8'hff);
					end
					DTC_MODE_RELOAD:
						ovf_set[gi] = low_inc[gi] && low_max;
					DTC_MODE_SPLIT:
						ovf_set[gi] = (gi == 0) && low_inc[gi] && low_max;
					default:
						ovf_set[gi] = 1'b0;
				endcase
				if (gi == 1 && split_high_ovf)
					ovf_set[gi] = 1'b1;
			end
			// software writes take priority over counting in the same cycle
			always_ff @(posedge ref_clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					low_q[gi] <= DTC_RST_COUNT;
					high_q[gi] <= DTC_RST_COUNT;
				end
				else if (clk_en_in)
				begin
					if (low_wr)
						low_q[gi] <= reg_wdata_in;
					else if (low_inc[gi])
					begin
						if (nib[gi].mode == DTC_MODE_RELOAD && low_max)
							low_q[gi] <= high_q[gi];
						else if (nib[gi].mode == DTC_MODE_13BIT && low_max)
							low_q[gi] <= {low_q[gi][7:5], 5'h00};
						else
							low_q[gi] <= low_q[gi] + 8'h01;
					end
					if (high_wr)
						high_q[gi] <= reg_wdata_in;
					else if (high_inc[gi] || (gi == 0 && split_high_inc))
						high_q[gi] <= high_q[gi] + 8'h01;
				end
			end
		end
	endgenerate

	// run/flag and mode registers; hardware set wins over any clear
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			run_flag_q <= DTC_RST_RUN_FLAG;
			mode_q <= DTC_RST_MODE;
		end
		else if (clk_en_in)
		begin
			if (reg_wr_in && reg_addr_in == DTC_ADDR_MODE)
				mode_q <= reg_wdata_in;
			if (wr_run_flag)
				run_flag_q <= reg_wdata_in;
			if (vector_ack_in[0])
				run_flag_q[DTC_BIT_T0_FLAG] <= 1'b0;
			if (vector_ack_in[1])
				run_flag_q[DTC_BIT_T1_FLAG] <= 1'b0;
			if (ovf_set[0])
				run_flag_q[DTC_BIT_T0_FLAG] <= 1'b1;
			if (ovf_set[1])
				run_flag_q[DTC_BIT_T1_FLAG] <= 1'b1;
		end
	end

	// sticky irq status, write one to clear, set wins
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			irq_stat_q <= DTC_RST_IRQ;
			irq_mask_q <= DTC_RST_IRQ;
			irq_out <= 1'b0;
			overflow_flag_out <= 2'h0;
		end
		else if (clk_en_in)
		begin
			if (reg_wr_in && reg_addr_in == DTC_ADDR_IRQ_MASK)
				irq_mask_q <= reg_wdata_in[1:0];
			if (reg_wr_in && reg_addr_in == DTC_ADDR_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~reg_wdata_in[1:0]) | ovf_set;
			else
				irq_stat_q <= irq_stat_q | ovf_set;
			// registered level; one cycle behind the status bit
			irq_out <= |(irq_stat_q & irq_mask_q);
			overflow_flag_out <= {run_flag_q[DTC_BIT_T1_FLAG], run_flag_q[DTC_BIT_T0_FLAG]};
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			reg_rdata_out <= 8'h00;
		else if (clk_en_in)
		begin
			reg_rdata_out <= 8'h00;
			if (reg_rd_in)
			begin
				case (reg_addr_in)
					DTC_ADDR_RUN_FLAG: reg_rdata_out <= run_flag_q;
					DTC_ADDR_MODE: reg_rdata_out <= mode_q;
					DTC_ADDR_T0_LOW: reg_rdata_out <= low_q[0];
					DTC_ADDR_T1_LOW: reg_rdata_out <= low_q[1];
					DTC_ADDR_T0_HIGH: reg_rdata_out <= high_q[0];
					DTC_ADDR_T1_HIGH: reg_rdata_out <= high_q[1];
					DTC_ADDR_IRQ_STAT: reg_rdata_out <= {6'h00, irq_stat_q};
					DTC_ADDR_IRQ_MASK: reg_rdata_out <= {6'h00, irq_mask_q};
					default: reg_rdata_out <= 8'h00;
				endcase
			end
		end
	end

	// a flag set by overflow must show the next cycle
	chk_flag_on_ovf: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && ovf_set[0] |=> run_flag_q[DTC_BIT_T0_FLAG])
		else $error("timer0 overflow did not set flag");
	chk_reload_copy: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[0].mode == DTC_MODE_RELOAD && low_inc[0] && low_q[0] == 8'hff
		&& !reg_wr_in |=> low_q[0] == $past(high_q[0]) && $stable(high_q[0]))
		else $error("mode 2 reload wrong");
	chk_t1_split_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[1].mode == DTC_MODE_SPLIT && !reg_wr_in |=> $stable(low_q[1]))
		else $error("timer1 counted in mode 3");
	chk_tick_spacing: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && tick12_q |=> !tick12_q)
		else $error("prescale tick too long");
	chk_gate_blocks: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		nib[0].gate_sel && !ext_gate[0] |-> !low_inc[0])
		else $error("gated timer0 counted");
	chk_stop_no_cnt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!run_flag_q[DTC_BIT_T0_RUN] |-> !low_inc[0])
		else $error("stopped timer0 counted");
	chk_mode0_carry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[0].mode == DTC_MODE_13BIT && low_inc[0] && low_q[0][4:0] == 5'h1f
		&& !reg_wr_in |=> high_q[0] == $past(high_q[0]) + 8'h01)
		else $error("mode 0 prescaler carry missing");
	chk_split_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && split_high_ovf |=> run_flag_q[DTC_BIT_T1_FLAG])
		else $error("split high overflow lost");
	// timer one reload, the path the bench exercises
	chk_reload_copy1: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[1].mode == DTC_MODE_RELOAD && low_inc[1] && low_q[1] == 8'hff
		&& !reg_wr_in |=> low_q[1] == $past(high_q[1]) && $stable(high_q[1]))
		else $error("timer1 mode 2 reload wrong");
	// timer one overflow must land in its flag
	chk_flag1_on_ovf: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && ovf_set[1] |=> run_flag_q[DTC_BIT_T1_FLAG])
		else $error("timer1 overflow did not set flag");
	// vector ack clears the flag unless a new overflow wins
	chk_ack_clears0: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && vector_ack_in[0] && !ovf_set[0] && !wr_run_flag
		|=> !run_flag_q[DTC_BIT_T0_FLAG])
		else $error("timer0 flag survived vector ack");
	// same for timer one
	chk_ack_clears1: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && vector_ack_in[1] && !ovf_set[1] && !wr_run_flag
		|=> !run_flag_q[DTC_BIT_T1_FLAG])
		else $error("timer1 flag survived vector ack");
	// tick only as the divider restarts
	chk_tick_phase: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		tick12_q |-> prescale_q == 4'h0)
		else $error("prescale tick out of phase");
	// divider never runs past its last count
	chk_prescale_range: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		prescale_q <= DTC_PRESCALE_LAST)
		else $error("prescaler out of range");
	// plain low byte step in mode 1
	chk_mode1_step: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[0].mode == DTC_MODE_16BIT && low_inc[0] && low_q[0] != 8'hff
		&& !reg_wr_in |=> low_q[0] == $past(low_q[0]) + 8'h01)
		else $error("mode 1 low byte step wrong");
	// low byte wrap carries into high byte
	chk_mode1_carry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[0].mode == DTC_MODE_16BIT && low_inc[0] && low_q[0] == 8'hff
		&& !reg_wr_in |=> low_q[0] == 8'h00 && high_q[0] == $past(high_q[0]) + 8'h01)
		else $error("mode 1 carry missing");
	// unused top bits of the prescaler are left alone
	chk_mode0_keep_top: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[0].mode == DTC_MODE_13BIT && low_inc[0] && !reg_wr_in
		|=> low_q[0][7:5] == $past(low_q[0][7:5]))
		else $error("mode 0 touched upper low bits");
	// high byte waits for the prescaler to wrap
	chk_mode0_no_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[0].mode == DTC_MODE_13BIT && low_q[0][4:0] != 5'h1f
		&& !reg_wr_in |=> $stable(high_q[0]))
		else $error("mode 0 high byte moved early");
	// reload overflow raises the flag too
	chk_reload_ovf: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[1].mode == DTC_MODE_RELOAD && low_inc[1] && low_q[1] == 8'hff
		|=> run_flag_q[DTC_BIT_T1_FLAG])
		else $error("reload overflow flag missing");
	// timer one gate pin
	chk_t1_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		nib[1].gate_sel && !ext_gate[1] |-> !low_inc[1])
		else $error("gated timer1 counted");
	// timer one run bit
	chk_t1_stop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!run_flag_q[DTC_BIT_T1_RUN] |-> !low_inc[1])
		else $error("stopped timer1 counted");
	// split high byte idles without timer one run
	chk_split_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && nib[0].mode == DTC_MODE_SPLIT && !run_flag_q[DTC_BIT_T1_RUN]
		&& !reg_wr_in |=> $stable(high_q[0]))
		else $error("split high byte ran while stopped");
	// counter mode counts pin edges only
	chk_pin_src: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		nib[0].ct_sel && !pin_fall[0] |-> !low_inc[0])
		else $error("counter mode counted without edge");
	// timer mode counts divider ticks only
	chk_timer_src: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!nib[0].ct_sel && !tick12_q |-> !low_inc[0])
		else $error("timer mode counted without tick");
	// a high-to-low step in the synchroniser becomes a fall next cycle
	chk_fall_detect: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && pin_sync_q[0] && !pin_meta_q[0] |=> pin_fall[0])
		else $error("pin fall not detected");
	// irq level follows masked status one cycle late
	chk_irq_level: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in |=> irq_out == |($past(irq_stat_q) & $past(irq_mask_q)))
		else $error("irq level wrong");
	// flag outputs mirror the register bits
	chk_flag_out: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in |=> overflow_flag_out == {$past(run_flag_q[DTC_BIT_T1_FLAG]),
		$past(run_flag_q[DTC_BIT_T0_FLAG])})
		else $error("overflow flag output wrong");
	// overflow is remembered in the sticky status
	chk_stat_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && ovf_set[0] |=> irq_stat_q[0])
		else $error("irq status not set");
	// mode register takes the written byte
	chk_mode_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		clk_en_in && reg_wr_in && reg_addr_in == DTC_ADDR_MODE |=> mode_q == $past(reg_wdata_in))
		else $error("mode register write lost");
endmodule
`default_nettype wire

// ---- test_dual_timer_counter_four_modes.sv ----
// test_dual_timer_counter_four_modes: self-checking bench for dtc_top.
// assumes dtc_pin_model drives the count and gate pins.
`timescale 1ns/1ns
`default_nettype none
module test_dual_timer_counter_four_modes
	import dtc_pkg::*;
;
	logic ref_clk_in;
	logic rst_in;
	logic clk_en_in;
	logic reg_wr_in, reg_rd_in, rd_seen, irq_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [1:0] vector_ack_in, count_pin, gate_pin, overflow_flag_out;
	logic [7:0] exp_q[$];
	int fail_count, comparisons, seed, n;
	dtc_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .vector_ack_in(vector_ack_in),
		.timer_zero_count_pin_in(count_pin[0]), .timer_one_count_pin_in(count_pin[1]),
		.timer_zero_gate_pin_in(gate_pin[0]), .timer_one_gate_pin_in(gate_pin[1]),
		.overflow_flag_out(overflow_flag_out), .irq_out(irq_out));
	dtc_pin_model pins_u (.ref_clk_in(ref_clk_in), .count_pin_out(count_pin),
		.gate_pin_out(gate_pin));
	// 10 MHz clock
	always #50 ref_clk_in = ~ref_clk_in;
	task automatic check(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t expected %h got %h", $time, e, g);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// the expected byte is queued as the strobe goes out
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_in);
		exp_q.push_back(e);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
	endtask
	task automatic wait_flag(input int i);
		int k;
		for (k = 0; k < 100; k++)
		begin
			@(posedge ref_clk_in);
			if (overflow_flag_out[i] === 1'b1)
				return;
		end
		fail_count++;
		$display("[FAIL] %0t flag wait timed out", $time);
		end_sim();
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk_in)
	begin
		if (rd_seen === 1'b1)
			check(exp_q.pop_front(), reg_rdata_out);
		rd_seen <= reg_rd_in;
	end
	initial
	begin
		seed = 64033;
		ref_clk_in = 1'b0;
		rst_in = 1'b1;
		clk_en_in = 1'b1;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		rd_seen = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		vector_ack_in = 2'h0;
		fail_count = 0;
		comparisons = 0;
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(DTC_ADDR_RUN_FLAG, DTC_RST_RUN_FLAG);
		rd(DTC_ADDR_MODE, DTC_RST_MODE);
		wr(8'hf0, 8'h55);
		rd(8'hf0, 8'h00);
		$display("reset values done");
		// mode 1 rollover, unmasked interrupt, then both clears
		wr(DTC_ADDR_IRQ_MASK, 8'h01);
		wr(DTC_ADDR_T0_LOW, 8'hff);
		wr(DTC_ADDR_T0_HIGH, 8'hff);
		wr(DTC_ADDR_MODE, 8'h01);
		wr(DTC_ADDR_RUN_FLAG, 8'h10);
		wait_flag(0);
		wr(DTC_ADDR_RUN_FLAG, 8'h20);
		rd(DTC_ADDR_T0_LOW, 8'h00);
		rd(DTC_ADDR_T0_HIGH, 8'h00);
		check(8'h01, {7'h0, irq_out});
		wr(DTC_ADDR_IRQ_STAT, 8'h01);
		repeat (2) @(posedge ref_clk_in);
		check(8'h00, {7'h0, irq_out});
		vector_ack_in <= 2'h1;
		@(posedge ref_clk_in);
		vector_ack_in <= 2'h0;
		repeat (2) @(posedge ref_clk_in);
		check(8'h00, {6'h0, overflow_flag_out});
		$display("mode 1 done");
		// mode 0 wrap keeps the three unused low bits
		wr(DTC_ADDR_T0_LOW, 8'hff);
		wr(DTC_ADDR_T0_HIGH, 8'hff);
		wr(DTC_ADDR_MODE, 8'h00);
		wr(DTC_ADDR_RUN_FLAG, 8'h10);
		wait_flag(0);
		wr(DTC_ADDR_RUN_FLAG, 8'h00);
		rd(DTC_ADDR_T0_LOW, 8'he0);
		rd(DTC_ADDR_T0_HIGH, 8'h00);
		// drop the sticky timer0 status so the next irq check starts clean
		wr(DTC_ADDR_IRQ_STAT, 8'h01);
		$display("mode 0 done");
		// reload, then five ticks of twelve clocks; stop lands 4 clocks after the fifth tick, 8 before the sixth
		wr(DTC_ADDR_T1_HIGH, 8'h5a);
		wr(DTC_ADDR_T1_LOW, 8'hff);
		wr(DTC_ADDR_MODE, 8'h20);
		wr(DTC_ADDR_RUN_FLAG, 8'h40);
		wait_flag(1);
		vector_ack_in <= 2'h2;
		@(posedge ref_clk_in);
		vector_ack_in <= 2'h0;
		repeat (2) @(posedge ref_clk_in);
		check(8'h00, {6'h0, overflow_flag_out});
		repeat (57) @(posedge ref_clk_in);
		wr(DTC_ADDR_RUN_FLAG, 8'h00);
		rd(DTC_ADDR_T1_LOW, 8'h5f);
		rd(DTC_ADDR_T1_HIGH, 8'h5a);
		check(8'h00, {7'h0, irq_out});
		// frozen block must ignore a register write
		clk_en_in <= 1'b0;
		wr(DTC_ADDR_T1_HIGH, 8'h00);
		clk_en_in <= 1'b1;
		rd(DTC_ADDR_T1_HIGH, 8'h5a);
		$display("mode 2 done");
		// split: high byte of timer 0 runs on timer 1 controls
		wr(DTC_ADDR_T1_LOW, 8'h10);
		wr(DTC_ADDR_T0_HIGH, 8'hff);
		wr(DTC_ADDR_MODE, 8'h33);
		wr(DTC_ADDR_RUN_FLAG, 8'h40);
		wait_flag(1);
		wr(DTC_ADDR_RUN_FLAG, 8'h00);
		rd(DTC_ADDR_T1_LOW, 8'h10);
		rd(DTC_ADDR_T0_HIGH, 8'h00);
		$display("mode 3 done");
		// gated pin counting: closed gate first, then a random burst
		wr(DTC_ADDR_T0_LOW, 8'h00);
		wr(DTC_ADDR_T0_HIGH, 8'h00);
		wr(DTC_ADDR_MODE, 8'h0d);
		wr(DTC_ADDR_RUN_FLAG, 8'h10);
		pins_u.pulse_edges(0, 3);
		rd(DTC_ADDR_T0_LOW, 8'h00);
		pins_u.set_gate(0, 1'b1);
		repeat (4) @(posedge ref_clk_in);
		n = 1 + ($random(seed) & 15);
		pins_u.pulse_edges(0, n);
		repeat (6) @(posedge ref_clk_in);
		pins_u.set_gate(0, 1'b0);
		rd(DTC_ADDR_T0_LOW, n[7:0]);
		$display("counter mode done");
		repeat (3) @(posedge ref_clk_in);
		end_sim();
	end
endmodule
`default_nettype wire
